// [shared/uhv_consts.svh]
// Summary of operation
// - Registers exist only in function 2, the high-speed host controller.
// - Micro-frame period equals 59488 plus 16 times the adjustment value.
// - Adjustment field sits in bits 13:8, any value 0 to 63.
// - Adjustment resets to 20h, giving 60000 bit times.
// - Wake mask bit zero reads one: mask register implemented.
// - Wake mask bits 1-4 map to ports 1-4; mask resets to Fh.
// - Basic mode bit 0 allows only one controller active; resets zero.
// - Boundary bit 1 limits read requests to 64 bytes.
// - Prefetch bit 2 enables host read prefetch; clear means none.
// - User size enable bit 4 selects the programmed read request size.
// - User size field 6:5: 00b means 128 bytes, others reserved; resets 00b.
// - Prefetch length field 14:8 in dwords resets to 10h.
// - Control defaults replaceable by SMBus or EEPROM autoload.
`ifndef UHV_CONSTS_SVH
`define UHV_CONSTS_SVH
`define UHV_OFS_FRAME     8'h60
`define UHV_OFS_MISC      8'h68
`define UHV_HOST_FUNC     3'h2
`define UHV_FLA_LSB       8
`define UHV_WAKE_LSB      16
`define UHV_PFL_LSB       8
`define UHV_URS_LSB       5
`define UHV_BIT_BASIC     0
`define UHV_BIT_BOUND     1
`define UHV_BIT_PREF      2
`define UHV_BIT_RSV3      3
`define UHV_BIT_USER      4
`define UHV_BIT_RSV15     15
`define UHV_FLA_RESET     6'h20
`define UHV_WAKE_RESET    5'h0f
`define UHV_PFL_RESET     7'h10
`define UHV_URS_RESET     2'h0
`define UHV_FRAME_BASE    16'he860
`define UHV_FRAME_STEP    5'h10
`define UHV_RRS_DEFAULT   11'h200
`define UHV_RRS_64        11'h040
`define UHV_RRS_128       11'h080
`endif

// [shared/uhv_pkg.sv]
package uhv_pkg;
    // Config access from the root complex: function, dword offset, byte enables
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [2:0] func;
        logic [7:0] offset;
        logic [3:0] byteEn;
        logic [31:0] data;
    } uhv_cfg_req_t;
    // Default override from SMBus or EEPROM loader
    typedef struct packed {
        logic       valid;
        logic [7:0] offset;
        logic [31:0] data;
    } uhv_load_req_t;
    // Settings handed to the consumers
    typedef struct packed {
        logic [15:0] frameBitTimes;
        logic [5:0]  frameLengthAdjustValue;
        logic [3:0]  portWakeMask;
        logic        basicMode;
        logic        hostPrefetchOn;
        logic [6:0]  prefetchLengthDwords;
        logic [10:0] maxReadBytes;
    } uhv_settings_t;
    typedef enum logic [1:0] {UHV_RRS_DEF, UHV_RRS_64B, UHV_RRS_USER} uhv_rrs_sel_t;
endpackage

// [src/uhv_read_size.sv]
`timescale 1ns/10ps
`include "uhv_consts.svh"
module uhv_read_size (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        boundary64,
    input  wire logic        userSizeOn,
    input  wire logic [1:0]  userSizeCode,
    output uhv_pkg::uhv_rrs_sel_t sizeSel,
    output logic [10:0]      maxReadBytes
);
    import uhv_pkg::*;
    logic [10:0] next_bytes;
    uhv_rrs_sel_t next_sel;

    always_comb begin
        next_bytes = `UHV_RRS_DEFAULT;
        next_sel   = UHV_RRS_DEF;
        if (userSizeOn) begin
            // Reserved codes fall back to the only defined size
            next_bytes = (userSizeCode == 2'h0) ? `UHV_RRS_128 : `UHV_RRS_128;
            next_sel   = UHV_RRS_USER;
        end
        if (boundary64 && `UHV_RRS_64 < next_bytes) begin
            next_bytes = `UHV_RRS_64;
            next_sel   = UHV_RRS_64B;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            maxReadBytes <= `UHV_RRS_DEFAULT;
            sizeSel      <= UHV_RRS_DEF;
        end else begin
            maxReadBytes <= next_bytes;
            sizeSel      <= next_sel;
        end
    end

    a_bound_limit: assert property (@(posedge clk) disable iff (rst)
        boundary64 |=> maxReadBytes == `UHV_RRS_64) else $error("boundary not applied");
    a_user_size: assert property (@(posedge clk) disable iff (rst)
        (userSizeOn && !boundary64) |=> maxReadBytes == `UHV_RRS_128) else $error("user size not used");
endmodule

// [src/uhv_config_regs.sv]
`timescale 1ns/10ps
`include "uhv_consts.svh"
module uhv_config_regs (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire uhv_pkg::uhv_cfg_req_t  cfgReq,
    input  wire uhv_pkg::uhv_load_req_t loadReq,
    output logic                       cfgAck,
    output logic [31:0]                cfgReadData,
    output uhv_pkg::uhv_settings_t     settings
);
    import uhv_pkg::*;

    // Whole 5-bit field value; bit zero is the fixed implemented flag, not a port
    localparam logic [4:0] WAKE_FIELD_RESET = `UHV_WAKE_RESET;

    logic [5:0]  frameLengthAdjustValue;
    logic [3:0]  portWakeMask;
    logic        basicMode;
    logic        boundary64;
    logic        hostPrefetchOn;
    logic        rsvBit3;
    logic        userSizeOn;
    logic [1:0]  userSizeCode;
    logic [6:0]  prefetchLengthDwords;
    logic        rsvBit15;
    logic [10:0] maxReadBytes;
    uhv_rrs_sel_t sizeSel;

    logic        cfgWr;
    logic        loadWr;
    logic [31:0] wrData;
    logic [3:0]  wrBe;
    logic [7:0]  wrOfs;

    function automatic logic [31:0] frame_word(input logic [5:0] fla, input logic [3:0] wake);
        frame_word = '0;
        frame_word[`UHV_FLA_LSB +: 6]  = fla;
        frame_word[`UHV_WAKE_LSB]      = 1'b1;
        frame_word[`UHV_WAKE_LSB+1 +: 4] = wake;
    endfunction

    function automatic logic [31:0] misc_word(input logic [3:0] lo, input logic [1:0] urs,
                                              input logic [6:0] pfl, input logic r15);
        misc_word = '0;
        misc_word[4:0]                = {lo[3], lo[2:0]} == 4'h0 ? 5'h00 : 5'h00;
        misc_word[`UHV_BIT_BASIC]     = lo[0];
        misc_word[`UHV_BIT_BOUND]     = lo[1];
        misc_word[`UHV_BIT_PREF]      = lo[2];
        misc_word[`UHV_BIT_USER]      = lo[3];
        misc_word[`UHV_URS_LSB +: 2]  = urs;
        misc_word[`UHV_PFL_LSB +: 7]  = pfl;
        misc_word[`UHV_BIT_RSV15]     = r15;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write source select; loader takes priority as it runs before software
    always_comb begin
        loadWr = loadReq.valid;
        cfgWr  = cfgReq.valid && cfgReq.write && !loadReq.valid
                 && cfgReq.func == `UHV_HOST_FUNC;
        wrData = loadWr ? loadReq.data : cfgReq.data;
        wrBe   = loadWr ? 4'hf : cfgReq.byteEn;
        wrOfs  = loadWr ? loadReq.offset : cfgReq.offset;
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame length adjust and wake mask
    always_ff @(posedge clk) begin
        if (rst) begin
            frameLengthAdjustValue <= `UHV_FLA_RESET;
            portWakeMask           <= WAKE_FIELD_RESET[4:1];
        end else if ((cfgWr || loadWr) && wrOfs == `UHV_OFS_FRAME) begin
            if (wrBe[1])
                frameLengthAdjustValue <= wrData[`UHV_FLA_LSB +: 6];
            if (wrBe[2])
                portWakeMask <= wrData[`UHV_WAKE_LSB+1 +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control word: mode, read size and prefetch bits
    always_ff @(posedge clk) begin
        if (rst) begin
            basicMode            <= 1'b0;
            boundary64           <= 1'b0;
            hostPrefetchOn       <= 1'b0;
            rsvBit3              <= 1'b0;
            userSizeOn           <= 1'b0;
            userSizeCode         <= `UHV_URS_RESET;
            prefetchLengthDwords <= `UHV_PFL_RESET;
            rsvBit15             <= 1'b0;
        end else if ((cfgWr || loadWr) && wrOfs == `UHV_OFS_MISC) begin
            if (wrBe[0]) begin
                basicMode      <= wrData[`UHV_BIT_BASIC];
                boundary64     <= wrData[`UHV_BIT_BOUND];
                hostPrefetchOn <= wrData[`UHV_BIT_PREF];
                rsvBit3        <= wrData[`UHV_BIT_RSV3];
                userSizeOn     <= wrData[`UHV_BIT_USER];
                userSizeCode   <= wrData[`UHV_URS_LSB +: 2];
            end
            if (wrBe[1]) begin
                prefetchLengthDwords <= wrData[`UHV_PFL_LSB +: 7];
                rsvBit15             <= wrData[`UHV_BIT_RSV15];
            end
        end
    end

    uhv_read_size u_read_size (
        .clk          (clk),
        .rst          (rst),
        .boundary64   (boundary64),
        .userSizeOn   (userSizeOn),
        .userSizeCode (userSizeCode),
        .sizeSel      (sizeSel),
        .maxReadBytes (maxReadBytes)
    );

    ////////////////////////////////////////////////////////////////////////
    // Config answer, one cycle after the access; other functions read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgAck      <= 1'b0;
            cfgReadData <= 32'h0;
        end else begin
            cfgAck      <= cfgReq.valid && !loadReq.valid;
            cfgReadData <= 32'h0;
            if (cfgReq.valid && !cfgReq.write && cfgReq.func == `UHV_HOST_FUNC) begin
                case (cfgReq.offset)
                    `UHV_OFS_FRAME: cfgReadData <= frame_word(frameLengthAdjustValue, portWakeMask);
                    `UHV_OFS_MISC:  cfgReadData <= misc_word({userSizeOn, hostPrefetchOn, boundary64, basicMode},
                                                             userSizeCode, prefetchLengthDwords, rsvBit15)
                                                   | {28'h0, rsvBit3, 3'h0};
                    default:        cfgReadData <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings to consumers, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            settings.frameBitTimes          <= `UHV_FRAME_BASE + 16'(`UHV_FRAME_STEP) * 16'(`UHV_FLA_RESET);
            settings.frameLengthAdjustValue <= `UHV_FLA_RESET;
            settings.portWakeMask           <= WAKE_FIELD_RESET[4:1];
            settings.basicMode              <= 1'b0;
            settings.hostPrefetchOn         <= 1'b0;
            settings.prefetchLengthDwords   <= `UHV_PFL_RESET;
            settings.maxReadBytes           <= `UHV_RRS_DEFAULT;
        end else begin
            settings.frameBitTimes <= `UHV_FRAME_BASE
                                      + 16'(`UHV_FRAME_STEP) * {10'h0, frameLengthAdjustValue};
            settings.frameLengthAdjustValue <= frameLengthAdjustValue;
            settings.portWakeMask           <= portWakeMask;
            settings.basicMode              <= basicMode;
            settings.hostPrefetchOn         <= hostPrefetchOn;
            // Length held even when off; consumer ignores it then
            settings.prefetchLengthDwords   <= prefetchLengthDwords;
            settings.maxReadBytes           <= maxReadBytes;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_frame_period: assert property (@(posedge clk) disable iff (rst)
        ##2 settings.frameBitTimes == 16'he860 + 16'h10 * {10'h0, $past(frameLengthAdjustValue)})
        else $error("frame period mismatch");
    a_frame_reset: assert property (@(posedge clk) $fell(rst) |-> frameLengthAdjustValue == 6'h20
        && settings.frameBitTimes == 16'd60000) else $error("frame reset value wrong");
    a_wake_impl: assert property (@(posedge clk) disable iff (rst)
        (cfgAck && $past(cfgReq.offset) == 8'h60 && $past(cfgReq.func) == 3'h2 && !$past(cfgReq.write))
        |-> cfgReadData[16]) else $error("wake implemented bit low");
    a_wake_reset: assert property (@(posedge clk) $fell(rst) |-> portWakeMask == 4'h7)
        else $error("wake mask reset wrong");
    a_other_func: assert property (@(posedge clk) disable iff (rst)
        (cfgReq.valid && cfgReq.func != 3'h2) |=> cfgReadData == 32'h0) else $error("other function saw data");
    a_misc_reset: assert property (@(posedge clk) $fell(rst) |-> !basicMode && !boundary64 && !hostPrefetchOn
        && userSizeCode == 2'h0 && prefetchLengthDwords == 7'h10) else $error("misc reset wrong");
    a_load_write: assert property (@(posedge clk) disable iff (rst)
        (loadReq.valid && loadReq.offset == 8'h68) |=> basicMode == $past(loadReq.data[0])
        && prefetchLengthDwords == $past(loadReq.data[14:8])) else $error("load not applied");
    a_basic_out: assert property (@(posedge clk) disable iff (rst)
        basicMode |=> settings.basicMode) else $error("basic mode not passed on");
    a_pref_out: assert property (@(posedge clk) disable iff (rst)
        !hostPrefetchOn |=> !settings.hostPrefetchOn) else $error("prefetch on while disabled");
    a_size_sel: assert property (@(posedge clk) disable iff (rst)
        (sizeSel == UHV_RRS_USER) |-> $past(userSizeOn) && maxReadBytes == 11'h080)
        else $error("user size select wrong");
    a_size_smaller: assert property (@(posedge clk) disable iff (rst)
        (boundary64 && userSizeOn) |=> ##1 settings.maxReadBytes == 11'h040)
        else $error("smaller read size not used");
    a_load_drops_cfg: assert property (@(posedge clk) disable iff (rst)
        loadReq.valid |=> !cfgAck) else $error("access acknowledged during load");
    a_adj_write: assert property (@(posedge clk) disable iff (rst)
        (cfgWr && wrOfs == 8'h60 && wrBe[1]) |=> frameLengthAdjustValue == $past(wrData[13:8]))
        else $error("adjust write not applied");
    a_wake_write: assert property (@(posedge clk) disable iff (rst)
        (cfgWr && wrOfs == 8'h60 && wrBe[2]) |=> portWakeMask == $past(wrData[20:17]))
        else $error("wake mask write not applied");
    a_length_out: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> settings.prefetchLengthDwords == $past(prefetchLengthDwords))
        else $error("prefetch length not passed on");
endmodule

// [dv/uhv_root_model.sv]
`timescale 1ns/10ps
module uhv_root_model (
    input  wire logic             clk,
    input  wire logic             cfgAck,
    input  wire logic [31:0]      cfgReadData,
    output uhv_pkg::uhv_cfg_req_t cfgReq
);
    import uhv_pkg::*;
    initial cfgReq = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // One access: launched after an edge, taken at the next, answer read just after
    task automatic access(input logic wr, input logic [2:0] fn, input logic [7:0] ofs, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        @(posedge clk);
        cfgReq <= '{1'b1, wr, fn, ofs, be, wd};
        @(posedge clk);
        // Released lines flip so stale values never look valid
        cfgReq <= '{1'b0, ~wr, ~fn, ~ofs, ~be, ~wd};
        #1;
        ok = (cfgAck === 1'b1);
        rd = cfgReadData;
    endtask
endmodule

// [dv/usb2_host_vendor_config_regs_tb_top.sv]
`timescale 1ns/10ps
`include "uhv_consts.svh"
module usb2_host_vendor_config_regs_tb_top;
    import uhv_pkg::*;
    logic          clk;
    logic          rst;
    uhv_cfg_req_t  cfgReq;
    uhv_load_req_t loadReq;
    logic          cfgAck;
    logic [31:0]   cfgReadData;
    uhv_settings_t settings;
    int            nErrors;
    int            nChecks;
    int            cycles;
    logic [31:0]   rd;
    logic          ok;
    logic [5:0]    adjTab [4] = '{6'h00, 6'h01, 6'h1f, 6'h3f};

    uhv_config_regs dut (.clk(clk), .rst(rst), .cfgReq(cfgReq), .loadReq(loadReq), .cfgAck(cfgAck),
                         .cfgReadData(cfgReadData), .settings(settings));
    uhv_root_model rc (.clk(clk), .cfgAck(cfgAck), .cfgReadData(cfgReadData), .cfgReq(cfgReq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nErrors++;
            give_verdict();
        end
    end

    task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
        rc.access(1'b1, `UHV_HOST_FUNC, ofs, be, d, rd, ok);
        check(32'(ok), 32'h1);
    endtask

    task automatic rdchk(input logic [2:0] fn, input logic [7:0] ofs, input logic [31:0] exp);
        rc.access(1'b0, fn, ofs, 4'hf, 32'h0, rd, ok);
        check(32'(ok), 32'h1);
        check(rd, exp);
    endtask

    // Settings lag the register by one cycle, read size by two
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic check_defaults;
        settle();
        check(32'(settings.frameBitTimes), 32'd60000);
        check(32'(settings.frameLengthAdjustValue), 32'h20);
        check(32'({settings.basicMode, settings.hostPrefetchOn}), 32'h0);
        check(32'(settings.prefetchLengthDwords), 32'h10);
        check(32'(settings.portWakeMask), 32'h7);
        check(32'(settings.maxReadBytes), 32'd512);
        rdchk(3'h2, `UHV_OFS_FRAME, 32'h000f2000);
        rdchk(3'h2, `UHV_OFS_MISC, 32'h00001000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        loadReq = '0;
        nErrors = 0;
        nChecks = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        check_defaults();
        $display("test reset defaults done");
        foreach (adjTab[i]) begin
            wr(`UHV_OFS_FRAME, 4'h2, {18'h0, adjTab[i], 8'h0});
            settle();
            check(32'(settings.frameBitTimes), 32'd59488 + 32'd16 * adjTab[i]);
            rdchk(3'h2, `UHV_OFS_FRAME, {16'h000f, 2'h0, adjTab[i], 8'h0});
        end
        $display("test frame length done");
        wr(`UHV_OFS_FRAME, 4'h4, 32'h0);
        rdchk(3'h2, `UHV_OFS_FRAME, 32'h00013f00);
        wr(`UHV_OFS_FRAME, 4'h4, 32'h001a0000);
        settle();
        check(32'(settings.portWakeMask), 32'hd);
        rdchk(3'h2, `UHV_OFS_FRAME, 32'h001b3f00);
        $display("test wake mask done");
        for (int i = 0; i < 4; i++) begin
            wr(`UHV_OFS_MISC, 4'h3, {16'h0, 8'h20, 3'b000, i[1], 1'b0, ~i[0], i[0], i[1]});
            settle();
            check(32'(settings.basicMode), 32'(i[1]));
            check(32'(settings.hostPrefetchOn), {31'h0, ~i[0]});
            check(32'(settings.prefetchLengthDwords), 32'h20);
            check(32'(settings.maxReadBytes), i[0] ? 32'd64 : (i[1] ? 32'd128 : 32'd512));
        end
        $display("test misc controls done");
        // User size code kept at its only defined value
        wr(`UHV_OFS_MISC, 4'hf, 32'hffffff9f);
        settle();
        check(32'(settings.maxReadBytes), 32'd64);
        rdchk(3'h2, `UHV_OFS_MISC, 32'h0000ff1f);
        rc.access(1'b1, 3'h0, `UHV_OFS_MISC, 4'hf, 32'h0, rd, ok);
        rdchk(3'h2, `UHV_OFS_MISC, 32'h0000ff1f);
        rdchk(3'h0, `UHV_OFS_MISC, 32'h0);
        rdchk(3'h2, 8'h64, 32'h0);
        $display("test reserved and unmapped done");
        fork
            rc.access(1'b1, 3'h2, `UHV_OFS_MISC, 4'hf, 32'h0, rd, ok);
            begin
                @(posedge clk);
                loadReq <= '{1'b1, `UHV_OFS_MISC, 32'h00002a15};
                @(posedge clk);
                loadReq <= '0;
            end
        join
        check(32'(ok), 32'h0);
        settle();
        check(32'({settings.basicMode, settings.hostPrefetchOn}), 32'h3);
        check(32'(settings.prefetchLengthDwords), 32'h2a);
        check(32'(settings.maxReadBytes), 32'd128);
        rdchk(3'h2, `UHV_OFS_MISC, 32'h00002a15);
        $display("test loader override done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_defaults();
        $display("test second reset done");
        give_verdict();
    end
endmodule
